// [core/pmbus_cmd_pkg.sv]
// Constants and carriers for the scale-loop, output floor and frequency commands
// Shared by the command block and its linear-format decoder
package pmbus_cmd_pkg;
  localparam logic [7:0]  CMD_SCALE_LOOP  = 8'h29;
  localparam logic [7:0]  CMD_VOUT_FLOOR  = 8'h2b;
  localparam logic [7:0]  CMD_FREQ        = 8'h33;
  localparam int          EXP_LSB         = 11;
  localparam int          MAN_MSB         = 10;
  localparam logic [4:0]  SCALE_EXP_RESET = 5'h19;
  localparam logic [15:0] RESET_WORD      = 16'h0000;
  localparam int          FRAC_BITS       = 16;
  // Decoded values are unsigned with FRAC_BITS fraction bits
  localparam logic [31:0] Q_EIGHTH        = 32'h0000_2000;
  localparam logic [31:0] Q_QUARTER       = 32'h0000_4000;
  localparam logic [31:0] Q_HALF          = 32'h0000_8000;
  localparam logic [31:0] Q_ONE           = 32'h0001_0000;
  localparam logic [31:0] Q_ZERO          = 32'h0000_0000;
  localparam logic [1:0]  DIV_EIGHTH      = 2'h0;
  localparam logic [1:0]  DIV_QUARTER     = 2'h1;
  localparam logic [1:0]  DIV_HALF        = 2'h2;
  localparam logic [1:0]  DIV_ONE         = 2'h3;
  // Shared valid range of the floor and the ceiling of the output voltage
  localparam logic [15:0] VOUT_LIMIT_LO   = 16'h0100;
  localparam logic [15:0] VOUT_LIMIT_HI   = 16'hb000;
  // Frequencies at or above this many kHz are refused
  localparam logic [15:0] FREQ_LIMIT      = 16'h0672;
  localparam logic [15:0] FREQ_SPLIT_ONE  = 16'h0400;
  localparam logic [15:0] FREQ_SPLIT_TWO  = 16'h0800;
  localparam logic [4:0]  FREQ_EXP_ZERO   = 5'h00;
  localparam logic [4:0]  FREQ_EXP_ONE    = 5'h01;
  localparam logic [4:0]  FREQ_EXP_TWO    = 5'h02;
  localparam int          FREQ_BINS       = 12;
  // Inclusive upper edge of each bin in kHz, index 0 lowest
  localparam logic [FREQ_BINS-1:0][10:0] FREQ_EDGE = {
    11'h671, 11'h578, 11'h4b0, 11'h3e8, 11'h334, 11'h2bc,
    11'h258, 11'h1f4, 11'h19a, 11'h15e, 11'h12c, 11'h0fa};
  localparam logic [FREQ_BINS-1:0][10:0] FREQ_VALUE = {
    11'h5dc, 11'h514, 11'h44c, 11'h384, 11'h2ee, 11'h28a,
    11'h226, 11'h1c2, 11'h177, 11'h145, 11'h113, 11'h0e1};

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        word;
    logic [7:0]  code;
    logic [15:0] data;
  } pmbus_req_t;

  typedef struct packed {
    logic byte_nota;
    logic word_vout;
    logic vout_minmax;
    logic cml_data;
  } status_t;
endpackage

// [core/level_sync.sv]
// Two-stage synchroniser for a level from a pin
// Assumes the level is slow against ref_clk
`timescale 1ns/1ps
module level_sync (
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic din,
  output logic      dout
);
  logic meta;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// [core/linear_decode.sv]
// Linear-format word to unsigned fixed point with FRAC_BITS fraction bits
// Pure logic; negative mantissa and overflow are flagged, value then unusable
`timescale 1ns/1ps
module linear_decode (
  input  wire logic [15:0] word,
  output logic [31:0]      value,
  output logic             neg,
  output logic             ovf
);
  int          shift;
  logic [63:0] wide;

  always_comb begin
    shift = int'($signed(word[15:pmbus_cmd_pkg::EXP_LSB])) + pmbus_cmd_pkg::FRAC_BITS;
    neg   = word[pmbus_cmd_pkg::MAN_MSB];
    wide  = {53'h0_0000_0000_0000, word[pmbus_cmd_pkg::MAN_MSB:0]};
    if (shift >= 0) begin
      wide = wide << shift;
    end else begin
      wide = wide >> (-shift);
    end
    ovf   = |wide[63:32];
    value = wide[31:0];
  end
endmodule

// [core/pmbus_scale_min_freq_cmds.sv]
// Scale-loop, output floor and switching-frequency commands of the PMBus slave
// Assumes a decoded command strobe from the PMBus slave on ref_clk
//
// Functional notes
// R1: These three commands use Write Word and Read Word only.
// R2: Hardware takes writes at once when disabled, else on restore or UVLO. On restore it loads the NVM values and the written values are lost.
// R3: Scale loop is linear: exponent 15:11 resets to 11001b, mantissa from NVM.
// R4: Scale loop value programs the internal feedback divider.
// R5: Any in-range scale value is stored and reads back exactly.
// R6: Divider is 0.125, 0.25, 0.5 or 1.0 by decoded thresholds.
// R7: Reference scaling uses the actual programmed scale value.
// R8: Out-of-range scale or floor writes flag invalid data and alert.
// R9: Floor is a 16-bit value that bounds every output target.
// R10: Target below floor in conversion ramps to floor at programmed rate.
// R11: Floor violation sets byte, word and vout warning bits and alerts.
// R12: A ceiling that conflicts with the target warns the same way.
// R13: Floor valid range equals the ceiling valid range.
// R14: Frequency command is linear format in kHz.
// R15: Frequency exponent at reset derives from the NVM frequency.
// R16: Decoded frequency maps onto twelve supported bins up to 1500 kHz.
// R17: Host avoids above 1100 kHz without external bias on the rail.
// R18: Values in one-kHz gaps fall into the lower bin.
`timescale 1ns/1ps
module pmbus_scale_min_freq_cmds (
  input  wire logic                      ref_clk,
  input  wire logic                      nrst,
  input  wire pmbus_cmd_pkg::pmbus_req_t req,
  input  wire logic                      conv_enable,
  input  wire logic                      nvm_restore,
  input  wire logic                      analog_supply_uvlo,
  input  wire logic [15:0]               nvm_scale_loop,
  input  wire logic [15:0]               nvm_vout_floor,
  input  wire logic [15:0]               nvm_freq_khz,
  input  wire logic [15:0]               vout_request,
  input  wire logic                      vout_request_valid,
  input  wire logic [15:0]               vout_max,
  input  wire logic                      vout_max_wr,
  input  wire logic [15:0]               rate_step,
  input  wire logic                      clear_faults,
  output logic [15:0]                    rd_data,
  output logic                           rd_valid,
  output logic                           rd_hit,
  output logic [1:0]                     divider_sel,
  output logic [31:0]                    scale_applied,
  output logic [10:0]                    freq_applied_khz,
  output logic [15:0]                    vout_ref,
  output pmbus_cmd_pkg::status_t         status,
  output logic                           alert_n
);
  typedef enum logic {PH_LOAD, PH_RUN} phase_t;

  phase_t      phase;
  logic [15:0] output_scale_loop;
  logic [15:0] output_voltage_floor;
  logic [15:0] switching_frequency;
  logic [15:0] hw_scale_word;
  logic [15:0] hw_freq_word;
  logic [15:0] goal;
  logic [15:0] next_goal;
  logic [15:0] next_floor;
  logic [15:0] next_ref;
  logic [15:0] load_scale;
  logic [15:0] load_freq;
  logic [31:0] wr_dec;
  logic [31:0] hw_scale_dec;
  logic [31:0] hw_freq_dec;
  logic        wr_neg;
  logic        wr_ovf;
  logic        uvlo_s;
  logic        load_now;
  logic        data_ok;
  logic        bad_access;
  logic        good_write;
  logic        max_conflict;
  logic        warn_event;

  function automatic logic is_mine(input logic [7:0] code);
    return code == pmbus_cmd_pkg::CMD_SCALE_LOOP || code == pmbus_cmd_pkg::CMD_VOUT_FLOOR
        || code == pmbus_cmd_pkg::CMD_FREQ;
  endfunction

  function automatic logic [15:0] freq_to_linear(input logic [15:0] khz);
    logic [15:0] word;
    if (khz < pmbus_cmd_pkg::FREQ_SPLIT_ONE) begin
      word = {pmbus_cmd_pkg::FREQ_EXP_ZERO, khz[10:0]};
    end else if (khz < pmbus_cmd_pkg::FREQ_SPLIT_TWO) begin
      word = {pmbus_cmd_pkg::FREQ_EXP_ONE, khz[11:1]};
    end else begin
      word = {pmbus_cmd_pkg::FREQ_EXP_TWO, khz[12:2]};
    end
    return word;
  endfunction

  function automatic logic [10:0] freq_bin(input logic [15:0] khz);
    logic [10:0] bin;
    bin = pmbus_cmd_pkg::FREQ_VALUE[pmbus_cmd_pkg::FREQ_BINS-1];
    for (int i = pmbus_cmd_pkg::FREQ_BINS - 1; i >= 0; i--) begin
      if (khz <= 16'(pmbus_cmd_pkg::FREQ_EDGE[i])) begin
        bin = pmbus_cmd_pkg::FREQ_VALUE[i];
      end
    end
    return bin;
  endfunction

  function automatic logic [1:0] scale_to_div(input logic [31:0] q);
    logic [1:0] sel;
    if (q <= pmbus_cmd_pkg::Q_EIGHTH) begin
      sel = pmbus_cmd_pkg::DIV_EIGHTH;
    end else if (q <= pmbus_cmd_pkg::Q_QUARTER) begin
      sel = pmbus_cmd_pkg::DIV_QUARTER;
    end else if (q <= pmbus_cmd_pkg::Q_HALF) begin
      sel = pmbus_cmd_pkg::DIV_HALF;
    end else begin
      sel = pmbus_cmd_pkg::DIV_ONE;
    end
    return sel;
  endfunction

  level_sync u_uvlo_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .din     (analog_supply_uvlo),
    .dout    (uvlo_s)
  );

  linear_decode u_wr_dec (
    .word  (req.data),
    .value (wr_dec),
    .neg   (wr_neg),
    .ovf   (wr_ovf)
  );

  linear_decode u_scale_dec (
    .word  (hw_scale_word),
    .value (hw_scale_dec),
    .neg   (),
    .ovf   ()
  );

  linear_decode u_freq_dec (
    .word  (hw_freq_word),
    .value (hw_freq_dec),
    .neg   (),
    .ovf   ()
  );

  // Write validation and event decode
  always_comb begin
    load_now   = (phase == PH_LOAD) || nvm_restore;
    load_scale = {pmbus_cmd_pkg::SCALE_EXP_RESET, nvm_scale_loop[pmbus_cmd_pkg::MAN_MSB:0]}; // R3
    load_freq  = freq_to_linear(nvm_freq_khz); // R15
    case (req.code)
      pmbus_cmd_pkg::CMD_SCALE_LOOP: begin
        data_ok = !wr_neg && !wr_ovf && wr_dec != pmbus_cmd_pkg::Q_ZERO
               && wr_dec <= pmbus_cmd_pkg::Q_ONE; // R5
      end
      pmbus_cmd_pkg::CMD_VOUT_FLOOR: begin
        data_ok = req.data >= pmbus_cmd_pkg::VOUT_LIMIT_LO
               && req.data <= pmbus_cmd_pkg::VOUT_LIMIT_HI; // R13
      end
      pmbus_cmd_pkg::CMD_FREQ: begin
        data_ok = !wr_neg && !wr_ovf && wr_dec[31:16] < pmbus_cmd_pkg::FREQ_LIMIT;
      end
      default: begin
        data_ok = 1'b0;
      end
    endcase
    // Only word transactions are accepted
    bad_access = req.valid && is_mine(req.code) && (!req.word || (req.write && !data_ok)); // R1 R8
    good_write = req.valid && req.write && req.word && is_mine(req.code) && data_ok; // R1
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      phase <= PH_LOAD;
    end else begin
      case (phase)
        PH_LOAD: phase <= PH_RUN;
        PH_RUN:  phase <= PH_RUN;
        default: phase <= PH_LOAD;
      endcase
    end
  end

  // Stored command values; restore wins over a write in the same cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      output_scale_loop   <= {pmbus_cmd_pkg::SCALE_EXP_RESET, 11'h000}; // R3
      switching_frequency <= pmbus_cmd_pkg::RESET_WORD;
    end else if (load_now) begin
      output_scale_loop   <= load_scale; // R3
      switching_frequency <= load_freq; // R15
    end else if (good_write && req.code == pmbus_cmd_pkg::CMD_SCALE_LOOP) begin
      output_scale_loop   <= req.data; // R5
    end else if (good_write && req.code == pmbus_cmd_pkg::CMD_FREQ) begin
      switching_frequency <= req.data; // R14
    end
  end

  always_comb begin
    next_floor = output_voltage_floor;
    if (load_now) begin
      next_floor = nvm_vout_floor;
    end else if (good_write && req.code == pmbus_cmd_pkg::CMD_VOUT_FLOOR) begin
      next_floor = req.data; // R9
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      output_voltage_floor <= pmbus_cmd_pkg::RESET_WORD;
    end else begin
      output_voltage_floor <= next_floor;
    end
  end

  // Values in force in hardware; held while converting except on restore or UVLO
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hw_scale_word <= {pmbus_cmd_pkg::SCALE_EXP_RESET, 11'h000};
      hw_freq_word  <= pmbus_cmd_pkg::RESET_WORD;
    end else if (load_now) begin
      hw_scale_word <= load_scale; // R2
      hw_freq_word  <= load_freq; // R2
    end else if (uvlo_s) begin
      hw_scale_word <= output_scale_loop; // R2
      hw_freq_word  <= switching_frequency; // R2
    end else if (good_write && !conv_enable) begin
      if (req.code == pmbus_cmd_pkg::CMD_SCALE_LOOP) begin
        hw_scale_word <= req.data; // R2
      end
      if (req.code == pmbus_cmd_pkg::CMD_FREQ) begin
        hw_freq_word <= req.data; // R2
      end
    end
  end

  // Divider choice and bin mapping of the values in force
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      divider_sel      <= pmbus_cmd_pkg::DIV_ONE;
      scale_applied    <= pmbus_cmd_pkg::Q_ONE;
      freq_applied_khz <= pmbus_cmd_pkg::FREQ_VALUE[0];
    end else begin
      divider_sel      <= scale_to_div(hw_scale_dec); // R4 R6
      scale_applied    <= hw_scale_dec; // R7
      freq_applied_khz <= freq_bin(hw_freq_dec[31:16]); // R16 R18
    end
  end

  // Output target with floor clamp
  always_comb begin
    max_conflict = vout_max_wr && vout_max < goal;
    warn_event   = conv_enable && ((vout_request_valid && vout_request < next_floor)
                || max_conflict); // R10 R12
    next_goal    = goal;
    if (vout_request_valid) begin
      next_goal = vout_request;
    end
    if (max_conflict) begin
      next_goal = vout_max; // R12
    end
    if (next_goal < next_floor) begin
      next_goal = next_floor; // R9
    end
  end

  always_comb begin
    if (!conv_enable || rate_step == 16'h0000) begin
      next_ref = goal;
    end else if (vout_ref < goal) begin
      next_ref = (goal - vout_ref > rate_step) ? 16'(vout_ref + rate_step) : goal; // R10
    end else begin
      next_ref = (vout_ref - goal > rate_step) ? 16'(vout_ref - rate_step) : goal; // R10
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      goal     <= pmbus_cmd_pkg::RESET_WORD;
      vout_ref <= pmbus_cmd_pkg::RESET_WORD;
    end else begin
      goal     <= next_goal;
      vout_ref <= next_ref;
    end
  end

  // Sticky status; a set in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      status <= '0;
    end else begin
      status.byte_nota   <= warn_event || (status.byte_nota && !clear_faults); // R11
      status.word_vout   <= warn_event || (status.word_vout && !clear_faults); // R11
      status.vout_minmax <= warn_event || (status.vout_minmax && !clear_faults); // R11
      status.cml_data    <= bad_access || (status.cml_data && !clear_faults); // R8
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      alert_n <= 1'b1;
    end else begin
      alert_n <= !(|status); // R8 R11
    end
  end

  // Read answer one cycle after the request
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_valid <= 1'b0;
      rd_hit   <= 1'b0;
      rd_data  <= pmbus_cmd_pkg::RESET_WORD;
    end else begin
      rd_valid <= req.valid && !req.write;
      rd_hit   <= req.valid && !req.write && req.word && is_mine(req.code); // R1
      case (req.code)
        pmbus_cmd_pkg::CMD_SCALE_LOOP: rd_data <= output_scale_loop;
        pmbus_cmd_pkg::CMD_VOUT_FLOOR: rd_data <= output_voltage_floor;
        pmbus_cmd_pkg::CMD_FREQ:       rd_data <= switching_frequency;
        default:                       rd_data <= pmbus_cmd_pkg::RESET_WORD;
      endcase
    end
  end

  read_answer_a: // R1
    assert property (@(posedge ref_clk) disable iff (!nrst)
      req.valid && !req.write && req.word && req.code == pmbus_cmd_pkg::CMD_FREQ
      |=> rd_valid && rd_hit && rd_data == $past(switching_frequency))
    else $error("frequency read not answered");

  hold_enabled_a: // R2
    assert property (@(posedge ref_clk) disable iff (!nrst)
      conv_enable && !load_now && !uvlo_s |=> $stable(hw_scale_word) && $stable(hw_freq_word))
    else $error("hardware value changed while converting");

  exp_reset_a: // R3
    assert property (@(posedge ref_clk) disable iff (!nrst)
      load_now |=> output_scale_loop[15:11] == pmbus_cmd_pkg::SCALE_EXP_RESET)
    else $error("scale exponent not reloaded");

  scale_readback_a: // R5
    assert property (@(posedge ref_clk) disable iff (!nrst)
      good_write && !load_now && req.code == pmbus_cmd_pkg::CMD_SCALE_LOOP
      |=> output_scale_loop == $past(req.data))
    else $error("scale value not stored as written");

  divider_pick_a: // R6
    assert property (@(posedge ref_clk) disable iff (!nrst)
      hw_scale_dec > pmbus_cmd_pkg::Q_QUARTER && hw_scale_dec <= pmbus_cmd_pkg::Q_HALF
      |=> divider_sel == pmbus_cmd_pkg::DIV_HALF)
    else $error("wrong divider for scale value");

  invalid_flag_a: // R8
    assert property (@(posedge ref_clk) disable iff (!nrst)
      req.valid && req.write && req.word && req.code == pmbus_cmd_pkg::CMD_VOUT_FLOOR
      && req.data > pmbus_cmd_pkg::VOUT_LIMIT_HI
      |=> status.cml_data && $stable(output_voltage_floor) ##1 !alert_n)
    else $error("invalid floor write not flagged");

  floor_bound_a: // R9
    assert property (@(posedge ref_clk) disable iff (!nrst)
      phase == PH_RUN |-> goal >= output_voltage_floor)
    else $error("target below floor");

  warn_bits_a: // R11
    assert property (@(posedge ref_clk) disable iff (!nrst)
      conv_enable && vout_request_valid && !load_now && vout_request < output_voltage_floor
      |=> status.byte_nota && status.word_vout && status.vout_minmax ##1 !alert_n)
    else $error("floor violation not reported");

  freq_bin_a: // R16
    assert property (@(posedge ref_clk) disable iff (!nrst)
      hw_freq_dec[31:16] == 16'h00fa |=> freq_applied_khz == 11'h0e1)
    else $error("250 kHz not mapped to lowest bin");
endmodule

// [verification/pmbus_host_model.sv]
// Host stand-in for the command port: one word or byte transfer at a time
// Assumes the slave samples the strobe on the rising edge of ref_clk
`timescale 1ns/1ps
module pmbus_host_model (
  input  wire logic                 ref_clk,
  input  wire logic [15:0]          rd_data,
  input  wire logic                 rd_valid,
  output pmbus_cmd_pkg::pmbus_req_t req
);
  initial begin
    req = '0;
  end

  // Strobe held one cycle, answer taken after the taking edge
  task automatic xfer(input logic w, input logic wd, input logic [7:0] c,
                      input logic [15:0] d, output logic [15:0] q, output logic v);
    @(posedge ref_clk);
    req <= '{valid: 1'b1, write: w, word: wd, code: c, data: d};
    @(posedge ref_clk);
    req.valid <= 1'b0;
    // Released data no longer shows the last word
    req.data  <= ~d;
    #1;
    q = rd_data;
    v = rd_valid;
  endtask
endmodule

// [verification/tb_pmbus_scale_min_freq_cmds.sv]
// Self-checking bench for the scale-loop, output floor and frequency commands
// Assumes the host stand-in model drives the command port
`timescale 1ns/1ps
module tb_pmbus_scale_min_freq_cmds;
  logic                      ref_clk, nrst, conv_enable, nvm_restore, analog_supply_uvlo;
  logic [15:0]               nvm_scale_loop, nvm_vout_floor, nvm_freq_khz, vout_request;
  logic [15:0]               vout_max, rate_step, rd_data, vout_ref, q, w;
  logic                      vout_request_valid, vout_max_wr, clear_faults, rd_valid, rd_hit;
  logic                      alert_n, v;
  logic [1:0]                divider_sel;
  logic [31:0]               scale_applied;
  logic [10:0]               freq_applied_khz, m;
  pmbus_cmd_pkg::status_t    status;
  pmbus_cmd_pkg::pmbus_req_t req;
  int                        failures, tests_run, cycles;
  localparam logic [10:0] EDGE_K [12] = '{11'h0fa, 11'h12c, 11'h15e, 11'h19a, 11'h1f4,
    11'h258, 11'h2bc, 11'h334, 11'h3e8, 11'h4b0, 11'h578, 11'h671};
  localparam logic [10:0] BIN_K [12] = '{11'h0e1, 11'h113, 11'h145, 11'h177, 11'h1c2,
    11'h226, 11'h28a, 11'h2ee, 11'h384, 11'h44c, 11'h514, 11'h5dc};
  localparam logic [10:0] SCL_K [8] = '{11'h010, 11'h011, 11'h020, 11'h021, 11'h040,
    11'h041, 11'h080, 11'h001};
  // Mantissa bit 10 is the sign, so values from 1024 kHz on use exponent 1
  localparam logic [15:0] FRQ_K [8] = '{16'h00f9, 16'h00fa, 16'h00fb, 16'h01f4, 16'h0a26,
    16'h0abd, 16'h0b38, 16'h0abc};
  localparam logic [24:0] BAD_K [7] = '{{8'h29, 16'hc881, 1'b1}, {8'h29, 16'hcfff, 1'b1},
    {8'h29, 16'hc800, 1'b1}, {8'h2b, 16'h00ff, 1'b1}, {8'h2b, 16'hb001, 1'b1},
    {8'h33, 16'h0b39, 1'b1}, {8'h33, 16'h0384, 1'b0}};

  pmbus_scale_min_freq_cmds uut (.ref_clk(ref_clk), .nrst(nrst), .req(req),
    .conv_enable(conv_enable), .nvm_restore(nvm_restore),
    .analog_supply_uvlo(analog_supply_uvlo), .nvm_scale_loop(nvm_scale_loop),
    .nvm_vout_floor(nvm_vout_floor), .nvm_freq_khz(nvm_freq_khz),
    .vout_request(vout_request), .vout_request_valid(vout_request_valid),
    .vout_max(vout_max), .vout_max_wr(vout_max_wr), .rate_step(rate_step),
    .clear_faults(clear_faults), .rd_data(rd_data), .rd_valid(rd_valid), .rd_hit(rd_hit),
    .divider_sel(divider_sel), .scale_applied(scale_applied),
    .freq_applied_khz(freq_applied_khz), .vout_ref(vout_ref), .status(status),
    .alert_n(alert_n));
  pmbus_host_model host (.ref_clk(ref_clk), .rd_data(rd_data), .rd_valid(rd_valid),
    .req(req));

  always #2.5 ref_clk = ~ref_clk;

  function automatic logic [1:0] div_of(input logic [31:0] s);
    if (s <= 32'h0000_2000) return 2'h0;
    if (s <= 32'h0000_4000) return 2'h1;
    if (s <= 32'h0000_8000) return 2'h2;
    return 2'h3;
  endfunction

  // Gap values land in the lower bin
  function automatic logic [10:0] bin_of(input logic [15:0] x);
    logic [15:0] f;
    f = 16'(x[10:0]) << x[15:11];
    for (int i = 0; i < 12; i++) begin
      if (f <= 16'(EDGE_K[i])) return BIN_K[i];
    end
    return 11'h5dc;
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic clr;
    @(posedge ref_clk);
    clear_faults <= 1'b1;
    @(posedge ref_clk);
    clear_faults <= 1'b0;
    tick(3);
  endtask

  task automatic request(input logic [15:0] x);
    @(posedge ref_clk);
    vout_request       <= x;
    vout_request_valid <= 1'b1;
    @(posedge ref_clk);
    vout_request_valid <= 1'b0;
    tick(1);
  endtask

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end

  initial begin
    void'($urandom(47));
    {ref_clk, nrst, conv_enable, nvm_restore, analog_supply_uvlo} = '0;
    {vout_request_valid, vout_max_wr, clear_faults} = '0;
    {vout_request, vout_max, rate_step} = '0;
    nvm_scale_loop = 16'h0040;
    nvm_vout_floor = 16'h0200;
    nvm_freq_khz   = 16'h01f4;
    tick(2);
    check("reset divider", divider_sel, 2'h3);
    check("reset freq", freq_applied_khz, 11'h0e1);
    check("reset status", {status, alert_n}, 5'h01);
    @(posedge ref_clk);
    nrst <= 1'b1;
    tick(3);
    host.xfer(1'b0, 1'b1, 8'h29, 16'h0000, q, v);
    check("scale load", {rd_valid, rd_hit, q}, 18'h3_c840);
    host.xfer(1'b0, 1'b1, 8'h33, 16'h0000, q, v);
    check("freq load", q, 16'h01f4);
    host.xfer(1'b0, 1'b1, 8'h2b, 16'h0000, q, v);
    check("floor load", q, 16'h0200);
    check("freq gap", freq_applied_khz, 11'h1c2);
    host.xfer(1'b0, 1'b1, 8'h30, 16'h0000, q, v);
    check("unmapped", {rd_valid, rd_hit, q}, 18'h2_0000);
    for (int i = 0; i < 16; i++) begin
      m = (i < 8) ? SCL_K[i] : 11'h001 + 11'($urandom_range(127));
      host.xfer(1'b1, 1'b1, 8'h29, {5'h19, m}, q, v);
      tick(2);
      host.xfer(1'b0, 1'b1, 8'h29, 16'h0000, q, v);
      check("scale readback", q, {5'h19, m});
      check("divider", divider_sel, div_of({12'h000, m, 9'h000}));
      check("scale applied", scale_applied, {12'h000, m, 9'h000});
    end
    // External bias assumed on the rail for bins above 1100 kHz
    for (int i = 0; i < 16; i++) begin
      w = (i < 8) ? FRQ_K[i] : {5'h00, 11'($urandom_range(1023))};
      host.xfer(1'b1, 1'b1, 8'h33, w, q, v);
      tick(3);
      host.xfer(1'b0, 1'b1, 8'h33, 16'h0000, q, v);
      check("freq readback", q, w);
      check("freq bin", freq_applied_khz, bin_of(w));
    end
    for (int i = 0; i < 7; i++) begin
      host.xfer(1'b0, 1'b1, BAD_K[i][24:17], 16'h0000, w, v);
      host.xfer(1'b1, BAD_K[i][0], BAD_K[i][24:17], BAD_K[i][16:1], q, v);
      tick(2);
      check("refused flag", {status.cml_data, alert_n}, 2'h2);
      host.xfer(1'b0, 1'b1, BAD_K[i][24:17], 16'h0000, q, v);
      check("refused kept", q, w);
      clr();
      check("flag cleared", {status, alert_n}, 5'h01);
    end
    host.xfer(1'b1, 1'b1, 8'h2b, 16'h0100, q, v);
    host.xfer(1'b1, 1'b1, 8'h2b, 16'hb000, q, v);
    host.xfer(1'b0, 1'b1, 8'h2b, 16'h0000, q, v);
    check("floor top", {status, q}, 20'h0_b000);
    host.xfer(1'b1, 1'b1, 8'h2b, 16'h0200, q, v);
    host.xfer(1'b1, 1'b1, 8'h33, 16'h01f4, q, v);
    @(posedge ref_clk);
    conv_enable <= 1'b1;
    host.xfer(1'b1, 1'b1, 8'h33, 16'h0384, q, v);
    tick(3);
    check("held freq", freq_applied_khz, 11'h1c2);
    @(posedge ref_clk);
    analog_supply_uvlo <= 1'b1;
    repeat (6) @(posedge ref_clk);
    analog_supply_uvlo <= 1'b0;
    tick(4);
    check("uvlo freq", freq_applied_khz, 11'h384);
    @(posedge ref_clk);
    nvm_restore <= 1'b1;
    @(posedge ref_clk);
    nvm_restore <= 1'b0;
    tick(3);
    check("restore freq", freq_applied_khz, 11'h1c2);
    host.xfer(1'b0, 1'b1, 8'h29, 16'h0000, q, v);
    check("restore scale", q, 16'hc840);
    @(posedge ref_clk);
    conv_enable <= 1'b0;
    rate_step   <= 16'h0020;
    request(16'h0300);
    tick(2);
    check("ref follows", vout_ref, 16'h0300);
    @(posedge ref_clk);
    conv_enable <= 1'b1;
    request(16'h0100);
    check("floor warn", status, 4'he);
    tick(2);
    check("floor alert", alert_n, 1'b0);
    check("ramping", vout_ref > 16'h0200, 1'b1);
    tick(20);
    check("ramp end", vout_ref, 16'h0200);
    clr();
    request(16'h0400);
    tick(24);
    check("no warn", {status, alert_n, vout_ref}, 21'h1_0400);
    @(posedge ref_clk);
    vout_max    <= 16'h0300;
    vout_max_wr <= 1'b1;
    @(posedge ref_clk);
    vout_max_wr <= 1'b0;
    tick(24);
    check("ceiling warn", {status, alert_n, vout_ref}, 21'h1c_0300);
    clr();
    wrap_up();
  end
endmodule
